// File: lcai_alarm_irq.v
`timescale 1ns/10ps
`include "lcai_alarm_regs.vh"

module lcai_alarm_irq #(
  parameter NCH = 8
) (
  input  wire           clk,
  input  wire           rstn,
  // Microprocessor register port
  input  wire [7:0]     regAddr,
  input  wire           regWrEn,
  input  wire           regRdEn,
  input  wire [7:0]     regWrData,
  output reg  [7:0]     regRdData,
  // Per-channel transmit side
  input  wire [NCH-1:0] transmitClockIn,
  output wire [NCH-1:0] injectBitError,
  // Per-channel live alarm inputs
  input  wire [NCH-1:0] driverFailIn,
  input  wire [NCH-1:0] fifoLimitIn,
  input  wire [NCH-1:0] codeViolIn,
  input  wire [NCH-1:0] lcvOverflowIn,
  input  wire [NCH-1:0] allOnesIn,
  input  wire [NCH-1:0] signalLossIn,
  input  wire [NCH-1:0] prbsDetectIn,
  // Interrupt pin, active low
  output reg            irqN
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  wire       pageGlobal;
  wire [2:0] chSel;
  wire [3:0] regSel;

  // Bit 7 picks the global page; channel pages repeat every 16 bytes
  assign pageGlobal = regAddr[`LCAI_BIT_PAGE_GLOBAL];
  assign chSel      = regAddr[6:4];
  assign regSel     = regAddr[3:0];

  // ---------------------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------------------
  reg globalIrqEn_q;
  reg ovfSelect_q;

  // Global enable and status-bit-4 source select
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      globalIrqEn_q <= 1'b0;
      ovfSelect_q   <= 1'b0;
    end else if (regWrEn) begin
      if (regAddr == `LCAI_OFS_GLOBAL_IRQ)
        globalIrqEn_q <= regWrData[`LCAI_BIT_GLOBAL_IE];
      if (regAddr == `LCAI_OFS_GLOBAL_CFG)
        ovfSelect_q <= regWrData[`LCAI_BIT_OVF_SEL];
    end
  end

  // ---------------------------------------------------------------------------
  // Per-channel registers
  // ---------------------------------------------------------------------------
  wire [NCH*8-1:0] enableBus;
  wire [NCH*8-1:0] statusBus;
  wire [NCH*8-1:0] changeBus;
  wire [NCH-1:0]   injCtrlBus;
  wire [NCH-1:0]   chIrq;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      reg  [7:0] enable_q;
      reg  [7:0] status_q;
      reg  [7:0] change_q;
      reg        injCtrl_q;
      reg  [7:0] status_d;
      wire       hit;
      wire       rdChange;

      // Channel numbers at or above NCH match no page and are ignored
      assign hit      = ~pageGlobal & ({29'd0, chSel} == g);
      assign rdChange = regRdEn & hit & (regSel == `LCAI_OFS_ALARM_CHANGE);

      // Live alarm vector; bits 7 and 3 stay zero
      always @* begin
        status_d                      = `LCAI_RST_STATUS;
        status_d[`LCAI_BIT_DRV_FAIL]  = driverFailIn[g];
        status_d[`LCAI_BIT_FIFO_LIMIT] = fifoLimitIn[g];
        status_d[`LCAI_BIT_CODE_VIOL] = ovfSelect_q ? lcvOverflowIn[g]
                                                    : codeViolIn[g];
        status_d[`LCAI_BIT_ALL_ONES]  = allOnesIn[g];
        status_d[`LCAI_BIT_SIG_LOSS]  = signalLossIn[g];
        status_d[`LCAI_BIT_PRBS_DET]  = prbsDetectIn[g];
      end

      // Status follows alarms whatever the enables; not host-writable
      always @(posedge clk or negedge rstn) begin
        if (!rstn)
          status_q <= `LCAI_RST_STATUS;
        else
          status_q <= status_d;
      end

      // Enable and inject control; unused enable bits kept zero
      // Inject bit is only the request; its edge is found on the tx clock
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          enable_q  <= `LCAI_RST_ENABLE;
          injCtrl_q <= 1'b0;
        end else if (regWrEn & hit) begin
          if (regSel == `LCAI_OFS_IRQ_ENABLE)
            enable_q <= regWrData & `LCAI_ALARM_MASK;
          if (regSel == `LCAI_OFS_INJECT_CTRL)
            injCtrl_q <= regWrData[`LCAI_BIT_INJECT];
        end
      end

      // Change flags: a fresh change beats the clear-on-read
      // Both directions count, so a cleared alarm interrupts as well
      always @(posedge clk or negedge rstn) begin
        if (!rstn)
          change_q <= `LCAI_RST_STATUS;
        else
          change_q <= ((rdChange ? 8'h00 : change_q)
                       | (status_d ^ status_q)) & `LCAI_ALARM_MASK;
      end

      // Channel's masked contribution to the pin
      assign chIrq[g] = |(change_q & enable_q);

      assign enableBus[g*8 +: 8] = enable_q;
      assign statusBus[g*8 +: 8] = status_q;
      assign changeBus[g*8 +: 8] = change_q;
      assign injCtrlBus[g]       = injCtrl_q;

      lcai_err_inject uInject (
        .clk             (clk),
        .rstn            (rstn),
        .transmitClockIn (transmitClockIn[g]),
        .injectCtrl      (injCtrl_q),
        .injectBitError  (injectBitError[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Interrupt pin
  // ---------------------------------------------------------------------------
  // Registered so the pin never glitches during a clearing read
  // Costs one cycle of latency against a combinational pin
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      irqN <= 1'b1;
    else
      irqN <= ~(globalIrqEn_q & (|chIrq));
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  reg  [7:0] rdMux;
  wire [2:0] rdCh;

  assign rdCh = chSel;

  // Unmapped and unused locations read zero
  always @* begin
    rdMux = `LCAI_RST_BYTE;
    if (regAddr == `LCAI_OFS_GLOBAL_IRQ)
      rdMux[`LCAI_BIT_GLOBAL_IE] = globalIrqEn_q;
    else if (regAddr == `LCAI_OFS_GLOBAL_CFG)
      rdMux[`LCAI_BIT_OVF_SEL] = ovfSelect_q;
    else if (!pageGlobal && ({29'd0, rdCh} < NCH)) begin
      case (regSel)
        `LCAI_OFS_INJECT_CTRL: begin
          rdMux[`LCAI_BIT_INJECT] = injCtrlBus[rdCh];
        end
        `LCAI_OFS_IRQ_ENABLE: begin
          rdMux = enableBus[rdCh*8 +: 8];
        end
        `LCAI_OFS_ALARM_STATUS: begin
          rdMux = statusBus[rdCh*8 +: 8];
        end
        `LCAI_OFS_ALARM_CHANGE: begin
          rdMux = changeBus[rdCh*8 +: 8];
        end
        default: begin
          rdMux = `LCAI_RST_BYTE;
        end
      endcase
    end
  end

  // Read data captured on the read strobe, held until the next read
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      regRdData <= `LCAI_RST_BYTE;
    else if (regRdEn)
      regRdData <= rdMux;
  end

endmodule // lcai_alarm_irq

// File: lcai_alarm_regs.vh
`ifndef LCAI_ALARM_REGS_VH
`define LCAI_ALARM_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (low nibble inside a channel page, high nibble = channel)
// ----------------------------------------------------------------------------
`define LCAI_OFS_INJECT_CTRL   4'h3
`define LCAI_OFS_IRQ_ENABLE    4'h4
`define LCAI_OFS_ALARM_STATUS  4'h5
`define LCAI_OFS_ALARM_CHANGE  4'h6
`define LCAI_OFS_GLOBAL_IRQ    8'h80
`define LCAI_OFS_GLOBAL_CFG    8'h81

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LCAI_BIT_INJECT        1
`define LCAI_BIT_DRV_FAIL      6
`define LCAI_BIT_FIFO_LIMIT    5
`define LCAI_BIT_CODE_VIOL     4
`define LCAI_BIT_ALL_ONES      2
`define LCAI_BIT_SIG_LOSS      1
`define LCAI_BIT_PRBS_DET      0
`define LCAI_BIT_GLOBAL_IE     0
`define LCAI_BIT_OVF_SEL       7
`define LCAI_BIT_PAGE_GLOBAL   7

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define LCAI_ALARM_MASK        8'h77
`define LCAI_RST_ENABLE        8'h00
`define LCAI_RST_STATUS        8'h00
`define LCAI_RST_BYTE          8'h00

`endif

// File: lcai_err_inject.v
`timescale 1ns/10ps
`include "lcai_alarm_regs.vh"

// One channel's bit-error request, sampled on rising edges of the (sampled)
// transmit clock. Emits a single-cycle pulse per zero-to-one transition.
module lcai_err_inject (
  input  wire clk,
  input  wire rstn,
  input  wire transmitClockIn,
  input  wire injectCtrl,
  output reg  injectBitError
);

  reg txClkPrev_q;
  reg injSample_q;
  wire txRise;

  // ---------------------------------------------------------------------------
  // Transmit clock edge detection
  // ---------------------------------------------------------------------------
  // Clock pin is treated as a synchronous level, so its rise is an enable
  assign txRise = transmitClockIn & ~txClkPrev_q;

  // Sample on each rise; a pulse only for a fresh 0->1 step of the bit
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txClkPrev_q    <= 1'b0;
      injSample_q    <= 1'b0;
      injectBitError <= 1'b0;
    end else begin
      txClkPrev_q    <= transmitClockIn;
      injectBitError <= 1'b0;
      if (txRise) begin
        injSample_q    <= injectCtrl;
        injectBitError <= injectCtrl & ~injSample_q;
      end
    end
  end

endmodule // lcai_err_inject

// File: lcai_alarm_irq_monitor.sv
`timescale 1ns/10ps
// ----------
// Port checker
// ----------
module lcai_alarm_irq_monitor #(parameter NCH = 8) (
  input wire           clk,
  input wire           rstn,
  input wire [7:0]     regAddr,
  input wire           regWrEn,
  input wire           regRdEn,
  input wire [7:0]     regWrData,
  input wire [7:0]     regRdData,
  input wire [NCH-1:0] transmitClockIn,
  input wire [NCH-1:0] injectBitError,
  input wire [NCH-1:0] driverFailIn,
  input wire [NCH-1:0] fifoLimitIn,
  input wire [NCH-1:0] codeViolIn,
  input wire [NCH-1:0] lcvOverflowIn,
  input wire [NCH-1:0] allOnesIn,
  input wire [NCH-1:0] signalLossIn,
  input wire [NCH-1:0] prbsDetectIn,
  input wire           irqN
);
  reg [NCH-1:0] drv_q, fifo_q, ones_q, loss_q, prbs_q;
  reg [7:0]     live_q;
  reg [4:0]     rd_q;
  reg           globalEn_q;
  wire [2:0]    ch = regAddr[6:4];
  // Expected status two stages behind the inputs, bit 4 left out as it is mode dependent
  always @(posedge clk) begin
    drv_q <= driverFailIn;
    fifo_q <= fifoLimitIn;
    ones_q <= allOnesIn;
    loss_q <= signalLossIn;
    prbs_q <= prbsDetectIn;
    live_q <= {1'b0, drv_q[ch], fifo_q[ch], 2'b00, ones_q[ch], loss_q[ch], prbs_q[ch]};
    rd_q <= {regRdEn & ~regAddr[7], regAddr[3:0]};
  end
  // Snooped global enable
  always @(posedge clk or negedge rstn)
    if (!rstn) globalEn_q <= 1'b0;
    else if (regWrEn && regAddr == 8'h80) globalEn_q <= regWrData[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_inject_one_cycle: assert property ((injectBitError & $past(injectBitError)) == 0)
    else $error("inject pulse longer than one cycle");
  a_inject_tx_edge: assert property ((injectBitError & ~($past(transmitClockIn)
    | $past(transmitClockIn, 2))) == 0) else $error("inject pulse without transmit clock");
  a_reset_quiet: assert property ($rose(rstn) |-> irqN && injectBitError == 0)
    else $error("outputs active after reset");
  a_global_gate: assert property (!globalEn_q && !$past(globalEn_q) |-> irqN)
    else $error("interrupt with global enable off");
  a_enable_unused: assert property (rd_q == 5'h14 |-> (regRdData & 8'h88) == 0)
    else $error("unused enable bits read nonzero");
  a_inject_unused: assert property (rd_q == 5'h13 |-> (regRdData & 8'hfd) == 0)
    else $error("unused inject bits read nonzero");
  a_change_unused: assert property (rd_q == 5'h16 |-> !regRdData[7] && !regRdData[3])
    else $error("unused change bits read nonzero");
  a_status_live: assert property (rd_q == 5'h15 && $past(rstn, 2)
    |-> (regRdData & 8'h67) == live_q) else $error("status differs from alarm inputs");
endmodule // lcai_alarm_irq_monitor
bind lcai_alarm_irq lcai_alarm_irq_monitor #(.NCH(NCH)) lcai_alarm_irq_monitor_i (
  .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regWrData(regWrData), .regRdData(regRdData), .transmitClockIn(transmitClockIn),
  .injectBitError(injectBitError), .driverFailIn(driverFailIn), .fifoLimitIn(fifoLimitIn),
  .codeViolIn(codeViolIn), .lcvOverflowIn(lcvOverflowIn), .allOnesIn(allOnesIn),
  .signalLossIn(signalLossIn), .prbsDetectIn(prbsDetectIn), .irqN(irqN));

// File: lcai_host_model.sv
`timescale 1ns/10ps
// ----------
// Host register port
// ----------
module lcai_host_model (
  input  wire       clk,
  output reg  [7:0] regAddr,
  output reg        regWrEn,
  output reg        regRdEn,
  output reg  [7:0] regWrData,
  input  wire [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 8'h00;
  end
  // Strobe spans one rising edge; data inverted after so no stale value lingers
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      regWrData = ~d;
    end
  endtask
  // Read data is registered, settled by the next falling edge
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      d = regRdData;
    end
  endtask
endmodule // lcai_host_model

// File: test_lcai_alarm_irq.sv
`timescale 1ns/10ps
module test_lcai_alarm_irq;
  reg  clk = 1'b0, rstn = 1'b0;
  reg  [7:0] txClk = 0, drvFail = 0, fifoLim = 0, codeViol = 0;
  reg  [7:0] lcvOvf = 0, allOnes = 0, sigLoss = 0, prbsDet = 0, rdVal;
  wire [7:0] regAddr, regWrData, regRdData, injectBitError;
  wire       regWrEn, regRdEn, irqN;
  integer    mismatches = 0, compares = 0, pulses = 0, otherPulses = 0;
  always #5 clk = ~clk;
  // Count inject pulses on channel 1, and any stray pulse on the other channels
  always @(posedge clk) begin
    if (injectBitError[1] === 1'b1) pulses <= pulses + 1;
    if ((injectBitError & 8'hfd) !== 8'h00) otherPulses <= otherPulses + 1;
  end
  lcai_alarm_irq #(.NCH(8)) lcai_alarm_irq_i (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .transmitClockIn(txClk), .injectBitError(injectBitError), .driverFailIn(drvFail),
    .fifoLimitIn(fifoLim), .codeViolIn(codeViol), .lcvOverflowIn(lcvOvf),
    .allOnesIn(allOnes), .signalLossIn(sigLoss), .prbsDetectIn(prbsDet), .irqN(irqN));
  lcai_host_model lcai_host_model_i (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin lcai_host_model_i.rd(a, rdVal); chk(rdVal, e); end
  endtask
  task idle(input integer n); repeat (n) @(negedge clk); endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Three transmit clock periods, slow against the system clock
  task txBurst; repeat (3) begin txClk[1] = 1; idle(3); txClk[1] = 0; idle(3); end endtask
  task t_reset;
    begin rdchk(8'h04, 8'h00); rdchk(8'h35, 8'h00); end
  endtask
  task t_enable;
    begin
      lcai_host_model_i.wr(8'h54, 8'hff);
      rdchk(8'h54, 8'h77);
      lcai_host_model_i.wr(8'h55, 8'hff);
      rdchk(8'h55, 8'h00);
      rdchk(8'h27, 8'h00);
    end
  endtask
  task t_status;
    begin
      {drvFail, fifoLim, codeViol, allOnes, sigLoss, prbsDet} = {6{8'h04}};
      idle(3);
      rdchk(8'h25, 8'h77);
      lcai_host_model_i.wr(8'h81, 8'h80);
      rdchk(8'h81, 8'h80);
      rdchk(8'h25, 8'h67);
      lcvOvf = 8'h04;
      idle(2);
      rdchk(8'h25, 8'h77);
      lcai_host_model_i.wr(8'h81, 8'h00);
      {drvFail, fifoLim, codeViol, allOnes, sigLoss, prbsDet, lcvOvf} = 56'h0;
      idle(3);
      rdchk(8'h26, 8'h77);
      rdchk(8'h26, 8'h00);
    end
  endtask
  task t_irq;
    begin
      lcai_host_model_i.wr(8'h24, 8'h40);
      drvFail[2] = 1;
      idle(4);
      chk({7'h0, irqN}, 8'h01);
      lcai_host_model_i.wr(8'h80, 8'h01);
      idle(2);
      chk({7'h0, irqN}, 8'h00);
      rdchk(8'h80, 8'h01);
      rdchk(8'h26, 8'h40);
      sigLoss[2] = 1;
      idle(4);
      chk({7'h0, irqN}, 8'h01);
      lcai_host_model_i.wr(8'h74, 8'h02);
      sigLoss[7] = 1;
      idle(4);
      chk({7'h0, irqN}, 8'h00);
      rdchk(8'h76, 8'h02);
      idle(2);
      chk({7'h0, irqN}, 8'h01);
    end
  endtask
  // The zero must stand at a transmit clock rise, so each write gets a burst
  task t_inject;
    begin
      lcai_host_model_i.wr(8'h13, 8'h00);
      txBurst;
      lcai_host_model_i.wr(8'h13, 8'h02);
      rdchk(8'h13, 8'h02);
      idle(4);
      chk(pulses[7:0], 8'h00);
      txBurst;
      chk(pulses[7:0], 8'h01);
      lcai_host_model_i.wr(8'h13, 8'h00);
      txBurst;
      chk(pulses[7:0], 8'h01);
      lcai_host_model_i.wr(8'h13, 8'h02);
      txBurst;
      chk(pulses[7:0], 8'h02);
      chk(otherPulses[7:0], 8'h00);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    t_reset;
    t_enable;
    t_status;
    t_irq;
    t_inject;
    results;
  end
endmodule // test_lcai_alarm_irq
